// ---- rtl/rst_seq_pkg.sv ----
// Package with constants and types for the reset filter and sequencer
package rst_seq_pkg;
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned POR_TIME_US     = 5000;                       // Power-on interval, 5 ms
  localparam int unsigned POR_CYCLES      = POR_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned FILTER_CLOCKS   = 4;                          // Low pulses shorter than this ignored
  localparam int unsigned LATCH_CLOCKS    = 5;                          // Internal reset latched on this clock
  localparam int unsigned HOLD_CLOCKS     = 18;                         // Internal reset hold count
  localparam int unsigned FETCH_DLY_MIN   = 5;
  localparam int unsigned FETCH_DLY_MAX   = 10;
  localparam int unsigned FETCH_DLY       = 6;                          // Chosen delay inside the window
  localparam logic [15:0] RESET_VECTOR    = 16'h000C;
  localparam int unsigned BYPASS_BIT_POS  = 5;                          // Recovery delay bypass bit in stop reg
  localparam logic [7:0]  WDOG_MODE_RST   = 8'h0F;
  localparam logic [7:0]  STOP_REC_RST    = 8'h20;
  localparam logic [7:0]  PORT2_MODE_RST  = 8'hFF;
  localparam logic [7:0]  PORT3_MODE_RST  = 8'h00;

  // Port 0 configuration after reset
  typedef enum logic [1:0] {
    P0_INPUT   = 2'h1,
    P0_ADDRESS = 2'h2
  } port0_cfg_t;

  // Reset cause flags
  typedef struct packed {
    logic power_on;
    logic watchdog;
    logic stop_recovery;
    logic external;
  } reset_cause_t;

  // Mode registers preserved over stop-mode recovery
  typedef struct packed {
    logic [7:0] watchdog_mode_reg;
    logic [7:0] stop_recovery_reg;
    logic [7:0] port_two_mode_reg;
    logic [7:0] port_three_mode_reg;
  } mode_regs_t;
endpackage

// ---- rtl/reset_filter_sequencer.sv ----
// Reset filter, power-on timer and reset sequencer
`timescale 1ns/100ps
// Function
// - Reset comes from power-on, watchdog, stop recovery or the external pin.
// - Power-on and watchdog resets drive the pin low for the whole timer interval.
// - The power-on reset output interval lasts five milliseconds.
// - External low pulses shorter than four clocks cause no reset.
// - Internal reset is latched on the fifth clock after detection.
// - Internal reset holds eighteen clocks or while the pin stays low, whichever longer.
// - During the reset hold data strobe is low and address strobe toggles.
// - Fetch starts at the reset vector five to ten clocks after release.
// - Stop recovery leaves the four preserved mode registers unchanged.
// - External program select low runs from external memory, else internal.
// - External mode reset sets port 0 as upper address and extended timing.
// - Software may clear the extended timing selection after reset.
// - Internal mode reset makes all port 0 lines inputs.
// - Power timer starts on power good, unbypassed stop recovery, or watchdog.
// - Bit five of the stop recovery register selects skipping the timer.
module reset_filter_sequencer
  import rst_seq_pkg::*;
#(
  parameter int unsigned POR_COUNT = POR_CYCLES
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic         power_good,
  input  wire logic         watchdog_timeout,
  input  wire logic         stop_recovery,
  input  wire logic         reset_pin_in_n,
  output logic              reset_pin_out,
  output logic              reset_pin_oe_n,
  input  wire logic         external_program_select_n,
  input  wire logic         mode_wr,
  input  wire mode_regs_t   mode_wr_data,
  input  wire logic         clear_ext_timing,
  output mode_regs_t        mode_regs,
  output logic              core_reset,
  output logic              address_strobe_n,
  output logic              data_strobe_n,
  output logic              fetch_start,
  output logic [15:0]       fetch_addr,
  output logic              internal_rom_en,
  output port0_cfg_t        port0_cfg,
  output logic              ext_timing,
  output reset_cause_t      last_cause
);
  // Two-flop synchronisers for pin and external events
  logic [1:0] pin_sync_r, pg_sync_r, eps_sync_r;
  logic       pin_low, pg_s, eps_low, pg_d_r;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pin_sync_r <= 2'h3;
      pg_sync_r  <= 2'h0;
      eps_sync_r <= 2'h3;
    end else begin
      pin_sync_r <= {pin_sync_r[0], reset_pin_in_n};
      pg_sync_r  <= {pg_sync_r[0], power_good};
      eps_sync_r <= {eps_sync_r[0], external_program_select_n};
    end
  end
  assign pin_low = ~pin_sync_r[1];
  assign pg_s    = pg_sync_r[1];
  assign eps_low = ~eps_sync_r[1];

  // Power-on timer trigger conditions
  logic stop_bypass, por_trig, por_busy, por_busy_nxt;
  logic [31:0] por_cnt_r;
  assign stop_bypass = mode_regs.stop_recovery_reg[BYPASS_BIT_POS];
  assign por_trig = (pg_s & ~pg_d_r) | watchdog_timeout | (stop_recovery & ~stop_bypass);
  assign por_busy = (por_cnt_r != 32'h0);

  // One-shot power-on timer counting the interval down
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      por_cnt_r <= 32'h0;
      pg_d_r    <= 1'b0;
    end else begin
      pg_d_r <= pg_s;
      if (por_trig)
        por_cnt_r <= POR_COUNT;
      else if (por_busy)
        por_cnt_r <= por_cnt_r - 32'h1;
    end
  end

  // Pin driver: low while the timer runs, input otherwise (pull-up external)
  logic drive_nxt;
  assign drive_nxt = por_trig | (por_busy & (por_cnt_r != 32'h1));
  assign por_busy_nxt = drive_nxt;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      reset_pin_out  <= 1'b0;
      reset_pin_oe_n <= 1'b1;
    end else begin
      reset_pin_out  <= 1'b0;
      reset_pin_oe_n <= ~drive_nxt;
    end
  end

  // Noise filter on the external pin, ignored while the device drives it
  logic [2:0] filt_cnt_r;
  logic       ext_detect;
  assign ext_detect = (filt_cnt_r == 3'(FILTER_CLOCKS));
  always_ff @(posedge mclk) begin
    if (!resetn)
      filt_cnt_r <= 3'h0;
    else if (!pin_low || !reset_pin_oe_n)
      filt_cnt_r <= 3'h0;
    else if (!ext_detect)
      filt_cnt_r <= filt_cnt_r + 3'h1;
  end

  // Sequencer: latch delay, hold count, release, fetch delay
  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_LATCH = 2'b01,
    S_HOLD  = 2'b10,
    S_FETCH = 2'b11
  } seq_state_t;
  seq_state_t seq_r;
  logic [4:0] seq_cnt_r;
  logic       int_src;
  assign int_src = por_busy_nxt | stop_recovery;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      seq_r     <= S_HOLD;
      seq_cnt_r <= 5'h0;
    end else begin
      case (seq_r)
        S_IDLE: begin
          seq_cnt_r <= 5'h1;
          if (int_src) begin
            seq_r     <= S_HOLD;
            seq_cnt_r <= 5'h0;
          end else if (ext_detect)
            seq_r <= S_LATCH;
        end
        S_LATCH: begin
          seq_cnt_r <= seq_cnt_r + 5'h1;
          // A timer or stop source must not wait behind the latch delay
          if (int_src) begin
            seq_r     <= S_HOLD;
            seq_cnt_r <= 5'h0;
          end else if (seq_cnt_r == 5'(LATCH_CLOCKS)) begin
            seq_r     <= S_HOLD;
            seq_cnt_r <= 5'h0;
          end
        end
        S_HOLD: begin
          // Counting 0 to HOLD_CLOCKS-1 gives exactly HOLD_CLOCKS cycles in hold
          if (seq_cnt_r != 5'(HOLD_CLOCKS - 1))
            seq_cnt_r <= seq_cnt_r + 5'h1;
          if (int_src || por_busy)
            seq_cnt_r <= 5'h0;
          else if (seq_cnt_r == 5'(HOLD_CLOCKS - 1) && !pin_low) begin
            seq_r     <= S_FETCH;
            seq_cnt_r <= 5'h0;
          end
        end
        S_FETCH: begin
          seq_cnt_r <= seq_cnt_r + 5'h1;
          if (int_src) begin
            seq_r     <= S_HOLD;
            seq_cnt_r <= 5'h0;
          end else if (seq_cnt_r == 5'(FETCH_DLY - 1))
            seq_r <= S_IDLE;
        end
        default: seq_r <= S_HOLD;
      endcase
    end
  end

  // Reset outputs and strobes; address strobe toggles each clock in S_HOLD
  logic in_reset;
  assign in_reset = (seq_r == S_HOLD) || (seq_r == S_FETCH);
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      core_reset       <= 1'b1;
      data_strobe_n    <= 1'b0;
      address_strobe_n <= 1'b1;
      fetch_start      <= 1'b0;
      fetch_addr       <= RESET_VECTOR;
    end else begin
      core_reset       <= in_reset;
      data_strobe_n    <= ~(seq_r == S_HOLD);
      address_strobe_n <= (seq_r == S_HOLD) ? ~address_strobe_n : 1'b1;
      fetch_start      <= (seq_r == S_FETCH) && (seq_cnt_r == 5'(FETCH_DLY - 1)) && !int_src;
      fetch_addr       <= RESET_VECTOR;
    end
  end

  // Reset cause record, captured at each new reset entry
  always_ff @(posedge mclk) begin
    if (!resetn)
      last_cause <= '0;
    else if (por_trig || stop_recovery || (seq_r == S_IDLE && ext_detect))
      last_cause <= '{power_on: pg_s & ~pg_d_r, watchdog: watchdog_timeout,
                      stop_recovery: stop_recovery, external: ext_detect};
  end

  // Preserved mode registers: stop recovery keeps them, other resets reload
  logic full_reset;
  assign full_reset = (pg_s & ~pg_d_r) | watchdog_timeout | (seq_r == S_LATCH);
  always_ff @(posedge mclk) begin
    if (!resetn)
      mode_regs <= '{WDOG_MODE_RST, STOP_REC_RST, PORT2_MODE_RST, PORT3_MODE_RST};
    else if (full_reset)
      mode_regs <= '{WDOG_MODE_RST, STOP_REC_RST, PORT2_MODE_RST, PORT3_MODE_RST};
    else if (mode_wr && !in_reset)
      mode_regs <= mode_wr_data;
  end

  // Program source and port 0 setup, applied while reset is held
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      internal_rom_en <= 1'b1;
      port0_cfg       <= P0_INPUT;
      ext_timing      <= 1'b0;
    end else if (in_reset) begin
      internal_rom_en <= ~eps_low;
      port0_cfg       <= eps_low ? P0_ADDRESS : P0_INPUT;
      ext_timing      <= eps_low;
    end else if (clear_ext_timing) begin
      ext_timing      <= 1'b0;
    end
  end
endmodule

// ---- tb/reset_filter_sequencer_monitor.sv ----
// Checker of the reset sequencer port relations
`timescale 1ns/100ps
module reset_filter_sequencer_monitor
  import rst_seq_pkg::*;
(
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        clear_ext_timing,
  input wire logic        reset_pin_out,
  input wire logic        reset_pin_oe_n,
  input wire logic        core_reset,
  input wire logic        address_strobe_n,
  input wire logic        data_strobe_n,
  input wire logic        fetch_start,
  input wire logic [15:0] fetch_addr,
  input wire logic        internal_rom_en,
  input wire port0_cfg_t  port0_cfg,
  input wire logic        ext_timing
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Pin driver, strobes and fetch relations
  chk_pin_drives_low: assert property (!reset_pin_oe_n |-> !reset_pin_out)
    else $error("reset pin driven high");
  chk_reset_thru_timer: assert property (!reset_pin_oe_n && $past(!reset_pin_oe_n) |-> core_reset)
    else $error("core reset low while pin driven");
  chk_strobe_toggle: assert property (!data_strobe_n && $past(!data_strobe_n) && $past(resetn)
    |-> address_strobe_n != $past(address_strobe_n)) else $error("address strobe not toggling");
  chk_idle_strobes: assert property (!core_reset |-> data_strobe_n && address_strobe_n)
    else $error("strobes active out of reset");
  chk_fetch_vector: assert property (fetch_start |-> fetch_addr == RESET_VECTOR && core_reset)
    else $error("fetch address wrong");
  chk_fetch_window: assert property ($rose(data_strobe_n) && core_reset |-> !fetch_start [*5] ##[1:6] fetch_start)
    else $error("fetch outside window");
  chk_fetch_pulse: assert property (fetch_start |=> !fetch_start)
    else $error("fetch pulse too long");
  chk_port0_mode: assert property (fetch_start |-> port0_cfg == (internal_rom_en ? P0_INPUT : P0_ADDRESS))
    else $error("port 0 mode wrong");
  chk_ext_timing_set: assert property (fetch_start |-> ext_timing == !internal_rom_en)
    else $error("extended timing wrong");
  chk_timing_clear: assert property (clear_ext_timing && !core_reset |=> !ext_timing)
    else $error("extended timing not cleared");
endmodule

// ---- tb/reset_board.sv ----
// Board model of the open-drain reset line with its pull-up
`timescale 1ns/100ps
module reset_board (
  input  wire logic oe_n,
  input  wire logic drive_val,
  input  wire logic board_low,
  output logic      reset_pin_in_n
);
  // Wired-AND of device driver and board switch, pulled up when released
  assign reset_pin_in_n = ((!oe_n && !drive_val) || board_low) ? 1'b0 : 1'b1;
endmodule

// ---- tb/reset_filter_sequencer_tb.sv ----
// Testbench of the reset filter and sequencer
`timescale 1ns/100ps
module reset_filter_sequencer_tb;
  import rst_seq_pkg::*;
  localparam int P = 20;
  logic         mclk, resetn, pg, wd, sr, sel_n, mwr, clr, low;
  logic         oe_n, pout, crst, as_n, ds_n, fs, rom, ext;
  wire          pin_n;
  mode_regs_t   mdat, mregs;
  logic [15:0]  fa;
  port0_cfg_t   p0;
  reset_cause_t cause;
  int           error_cnt, compares, n, d, drv, dsl;
  reset_filter_sequencer #(.POR_COUNT(P)) dut (.mclk(mclk), .resetn(resetn), .power_good(pg),
    .watchdog_timeout(wd), .stop_recovery(sr), .reset_pin_in_n(pin_n), .reset_pin_out(pout),
    .reset_pin_oe_n(oe_n), .external_program_select_n(sel_n), .mode_wr(mwr), .mode_wr_data(mdat),
    .clear_ext_timing(clr), .mode_regs(mregs), .core_reset(crst), .address_strobe_n(as_n),
    .data_strobe_n(ds_n), .fetch_start(fs), .fetch_addr(fa), .internal_rom_en(rom), .port0_cfg(p0),
    .ext_timing(ext), .last_cause(cause));
  reset_board brd (.oe_n(oe_n), .drive_val(pout), .board_low(low), .reset_pin_in_n(pin_n));
  // Clock of 100 ns period
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Count cycles with the pin driven and with data strobe low
  always @(posedge mclk) begin
    if (oe_n === 1'b0)
      drv++;
    if (ds_n === 1'b0)
      dsl++;
  end
  task cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  task give_verdict;
    $display("Compares %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Bounded wait for the fetch pulse, then reset must be over
  task wait_fetch;
    n = 0;
    while (fs !== 1'b1) begin
      cyc(1);
      n++;
      if (n > 400) begin
        chk(1'b0, "no fetch");
        give_verdict;
      end
    end
    chk(fa === RESET_VECTOR, "fetch vector");
    cyc(3);
    chk(crst === 1'b0 && ds_n === 1'b1, "still in reset");
  endtask
  task pin_low(input int k);
    low = 1'b1;
    cyc(k);
    low = 1'b0;
  endtask
  task t_power;
    d = drv;
    pg = 1'b0;
    cyc(5);
    pg = 1'b1;
    wait_fetch;
    chk(drv - d == P && cause.power_on === 1'b1, "power-on interval");
    $display("power-on test done");
  endtask
  task t_filter;
    pin_low(3);
    cyc(1);
    pin_low(3);
    cyc(40);
    chk(crst === 1'b0, "short pulses caused reset");
    $display("filter test done");
  endtask
  task t_ext;
    d = dsl;
    low = 1'b1;
    n = 0;
    // Pin low for four clocks; count clocks until core reset rises
    while (crst !== 1'b1) begin
      cyc(1);
      n++;
      if (n == 4)
        low = 1'b0;
      if (n > 40) begin
        chk(1'b0, "no reset from pin");
        give_verdict;
      end
    end
    chk(n == 4 + FILTER_CLOCKS + LATCH_CLOCKS, "latch delay");
    wait_fetch;
    chk(dsl - d == HOLD_CLOCKS && cause.external === 1'b1, "hold count");
    low = 1'b1;
    cyc(40);
    chk(crst === 1'b1 && ds_n === 1'b0, "not held while pin low");
    low = 1'b0;
    wait_fetch;
    $display("external reset test done");
  endtask
  task t_wdog;
    d = drv;
    wd = 1'b1;
    cyc(1);
    wd = 1'b0;
    chk(oe_n === 1'b0 && pin_n === 1'b0, "pin not driven low");
    wait_fetch;
    chk(drv - d == P && cause.watchdog === 1'b1, "watchdog interval");
    $display("watchdog test done");
  endtask
  task t_stop;
    mdat = {8'h3C, 8'h20, 8'h5A, 8'hA5};
    mwr = 1'b1;
    cyc(1);
    mwr = 1'b0;
    d = drv;
    sr = 1'b1;
    cyc(1);
    sr = 1'b0;
    wait_fetch;
    chk(drv == d && cause.stop_recovery === 1'b1, "bypassed recovery");
    chk(mregs === mdat, "mode registers lost");
    mdat.stop_recovery_reg = 8'h00;
    mwr = 1'b1;
    cyc(1);
    mwr = 1'b0;
    sr = 1'b1;
    cyc(1);
    sr = 1'b0;
    wait_fetch;
    chk(drv - d == P, "timer after recovery");
    $display("stop recovery test done");
  endtask
  task t_rom;
    sel_n = 1'b0;
    pin_low(4);
    wait_fetch;
    chk(rom === 1'b0 && p0 === P0_ADDRESS && ext === 1'b1, "external mode");
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    chk(ext === 1'b0, "timing not cleared");
    sel_n = 1'b1;
    pin_low(4);
    wait_fetch;
    chk(rom === 1'b1 && p0 === P0_INPUT && ext === 1'b0, "internal mode");
    $display("program mode test done");
  endtask
  // Main sequence
  initial begin
    {resetn, wd, sr, mwr, clr, low} = '0;
    {pg, sel_n} = 2'h3;
    mdat = '0;
    {error_cnt, compares, drv, dsl} = '0;
    cyc(16);
    chk(mregs === {WDOG_MODE_RST, STOP_REC_RST, PORT2_MODE_RST, PORT3_MODE_RST} && p0 === P0_INPUT, "reset values");
    resetn = 1'b1;
    wait_fetch;
    t_power;
    t_filter;
    t_ext;
    t_wdog;
    t_stop;
    t_rom;
    give_verdict;
  end
endmodule
bind reset_filter_sequencer reset_filter_sequencer_monitor mon (.mclk(mclk), .resetn(resetn),
  .clear_ext_timing(clear_ext_timing), .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n),
  .core_reset(core_reset), .address_strobe_n(address_strobe_n), .data_strobe_n(data_strobe_n),
  .fetch_start(fetch_start), .fetch_addr(fetch_addr), .internal_rom_en(internal_rom_en),
  .port0_cfg(port0_cfg), .ext_timing(ext_timing));
